//--- shared/host_port_pkg.sv
`default_nettype none
package host_port_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned NUM_CHAN = 2;
  localparam logic CHAN_A = 1'b0;
  localparam logic CHAN_B = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic SELECT_IDLE = 1'b1;
  localparam logic GP_OUT_RST = 1'b1;
  localparam logic READY_N_RST = 1'b1;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ_WAIT,
    BUS_READ_DRIVE,
    BUS_WRITE
  } bus_state_e;

  // host pins after synchronisation
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic sel_a_n;
    logic sel_b_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pin_s;

  // register access towards the channel cores
  typedef struct packed {
    logic rd;
    logic wr;
    logic chan;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // per-channel status from a channel core
  typedef struct packed {
    logic irq;
    logic irq_out_en;
    logic tx_ready;
    logic rx_ready;
  } chan_stat_s;

endpackage
`default_nettype wire

//--- design/host_bus_port.sv
`timescale 1ns/100ps
`default_nettype none
module host_bus_port (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // host bus pins
  input wire logic [2:0] reg_sel_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // channel pins
  output logic chan_a_irq_out_o,
  output logic chan_a_irq_out_oe_o,
  output logic chan_b_irq_out_o,
  output logic chan_b_irq_out_oe_o,
  output logic chan_a_gp_out_n_o,
  output logic chan_b_gp_out_n_o,
  output logic chan_a_tx_ready_n_o,
  output logic chan_b_tx_ready_n_o,
  output logic chan_a_rx_ready_n_o,
  output logic chan_b_rx_ready_n_o,
  // channel core side
  output host_port_pkg::reg_req_s req_o,
  input wire logic [7:0] chan_a_rd_data_i,
  input wire logic [7:0] chan_b_rd_data_i,
  input wire host_port_pkg::chan_stat_s chan_a_stat_i,
  input wire host_port_pkg::chan_stat_s chan_b_stat_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    host_port_pkg::pin_s sync1;
    host_port_pkg::pin_s sync2;
    logic rd_prev_n;
    logic wr_prev_n;
    host_port_pkg::bus_state_e state;
    host_port_pkg::reg_req_s req;
    logic [7:0] rdata;
    logic data_oe;
    logic [1:0] irq;
    logic [1:0] irq_oe;
    logic [1:0] gp_n;
    logic [1:0] tx_n;
    logic [1:0] rx_n;
  } port_state_s;

  localparam host_port_pkg::pin_s PIN_RST = '{
    rd_n: host_port_pkg::STROBE_IDLE,
    wr_n: host_port_pkg::STROBE_IDLE,
    sel_a_n: host_port_pkg::SELECT_IDLE,
    sel_b_n: host_port_pkg::SELECT_IDLE,
    addr: host_port_pkg::ADDR_RST,
    data: host_port_pkg::DATA_RST
  };

  localparam host_port_pkg::reg_req_s REQ_RST = '{
    rd: 1'b0,
    wr: 1'b0,
    chan: host_port_pkg::CHAN_A,
    addr: host_port_pkg::ADDR_RST,
    wdata: host_port_pkg::DATA_RST
  };

  localparam port_state_s STATE_RST = '{
    sync1: PIN_RST,
    sync2: PIN_RST,
    rd_prev_n: host_port_pkg::STROBE_IDLE,
    wr_prev_n: host_port_pkg::STROBE_IDLE,
    state: host_port_pkg::BUS_IDLE,
    req: REQ_RST,
    rdata: host_port_pkg::DATA_RST,
    data_oe: 1'b0,
    irq: 2'h0,
    irq_oe: 2'h0,
    gp_n: {2{host_port_pkg::GP_OUT_RST}},
    tx_n: {2{host_port_pkg::READY_N_RST}},
    rx_n: {2{host_port_pkg::READY_N_RST}}
  };

  port_state_s s_r;
  port_state_s s_nxt;
  host_port_pkg::chan_stat_s stat [2];

  // exactly one select low picks a channel; both or none is no access
  function automatic logic one_selected(input host_port_pkg::pin_s p);
    one_selected = p.sel_a_n ^ p.sel_b_n;
  endfunction

  function automatic logic which_chan(input host_port_pkg::pin_s p);
    which_chan = p.sel_a_n ? host_port_pkg::CHAN_B : host_port_pkg::CHAN_A;
  endfunction

  assign stat[0] = chan_a_stat_i;
  assign stat[1] = chan_b_stat_i;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    logic sel_ok;
    rd_fall = s_r.rd_prev_n && !s_r.sync2.rd_n;
    rd_rise = !s_r.rd_prev_n && s_r.sync2.rd_n;
    wr_fall = s_r.wr_prev_n && !s_r.sync2.wr_n;
    wr_rise = !s_r.wr_prev_n && s_r.sync2.wr_n;
    sel_ok = one_selected(s_r.sync2);
    s_nxt = s_r;
    s_nxt.sync1 = '{
      rd_n: read_strobe_n_i,
      wr_n: write_strobe_n_i,
      sel_a_n: chan_a_select_n_i,
      sel_b_n: chan_b_select_n_i,
      addr: reg_sel_i,
      data: data_i
    };
    s_nxt.sync2 = s_r.sync1;
    s_nxt.rd_prev_n = s_r.sync2.rd_n;
    s_nxt.wr_prev_n = s_r.sync2.wr_n;
    s_nxt.req.rd = 1'b0;
    s_nxt.req.wr = 1'b0;
    unique case (s_r.state)
      host_port_pkg::BUS_IDLE:
      begin
        s_nxt.data_oe = 1'b0;
        if (sel_ok && rd_fall)
        begin
          s_nxt.req.rd = 1'b1;
          s_nxt.req.chan = which_chan(s_r.sync2);
          s_nxt.req.addr = s_r.sync2.addr;
          s_nxt.state = host_port_pkg::BUS_READ_WAIT;
        end
        else if (sel_ok && wr_fall)
        begin
          s_nxt.req.chan = which_chan(s_r.sync2);
          s_nxt.state = host_port_pkg::BUS_WRITE;
        end
      end
      host_port_pkg::BUS_READ_WAIT:
      begin
        s_nxt.rdata = (s_r.req.chan == host_port_pkg::CHAN_B) ?
                      chan_b_rd_data_i : chan_a_rd_data_i;
        s_nxt.data_oe = sel_ok && !s_r.sync2.rd_n;
        s_nxt.state = s_nxt.data_oe ? host_port_pkg::BUS_READ_DRIVE : host_port_pkg::BUS_IDLE;
      end
      host_port_pkg::BUS_READ_DRIVE:
      begin
        if (rd_rise || !sel_ok)
        begin
          s_nxt.data_oe = 1'b0;
          s_nxt.state = host_port_pkg::BUS_IDLE;
        end
      end
      host_port_pkg::BUS_WRITE:
      begin
        if (!sel_ok)
        begin
          s_nxt.state = host_port_pkg::BUS_IDLE;
        end
        else if (wr_rise)
        begin
          s_nxt.req.wr = 1'b1;
          s_nxt.req.addr = s_r.sync2.addr;
          s_nxt.req.wdata = s_r.sync2.data;
          s_nxt.state = host_port_pkg::BUS_IDLE;
        end
      end
    endcase
    for (int c = 0; c < 2; c++)
    begin
      s_nxt.irq[c] = stat[c].irq;
      s_nxt.irq_oe[c] = stat[c].irq_out_en;
      s_nxt.gp_n[c] = !stat[c].irq_out_en;
      s_nxt.tx_n[c] = !stat[c].tx_ready;
      s_nxt.rx_n[c] = !stat[c].rx_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_r <= STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign req_o = s_r.req;
  assign data_o = s_r.rdata;
  assign data_oe_o = s_r.data_oe;
  assign chan_a_irq_out_o = s_r.irq[0];
  assign chan_a_irq_out_oe_o = s_r.irq_oe[0];
  assign chan_b_irq_out_o = s_r.irq[1];
  assign chan_b_irq_out_oe_o = s_r.irq_oe[1];
  assign chan_a_gp_out_n_o = s_r.gp_n[0];
  assign chan_b_gp_out_n_o = s_r.gp_n[1];
  assign chan_a_tx_ready_n_o = s_r.tx_n[0];
  assign chan_b_tx_ready_n_o = s_r.tx_n[1];
  assign chan_a_rx_ready_n_o = s_r.rx_n[0];
  assign chan_b_rx_ready_n_o = s_r.rx_n[1];

endmodule // host_bus_port
`default_nettype wire

//--- verif/host_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_checker (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic read_strobe_n_i,
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic data_oe_o,
  input wire logic chan_a_irq_out_oe_o,
  input wire logic chan_a_gp_out_n_o,
  input wire logic chan_a_tx_ready_n_o,
  input wire logic chan_b_rx_ready_n_o,
  input wire host_port_pkg::reg_req_s req_o,
  input wire host_port_pkg::chan_stat_s chan_a_stat_i,
  input wire host_port_pkg::chan_stat_s chan_b_stat_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_idle;
    (chan_a_select_n_i && chan_b_select_n_i) [*5];
  endsequence
  sequence s_rd_fall;
    $fell(read_strobe_n_i) && (chan_a_select_n_i != chan_b_select_n_i);
  endsequence
  property p_gp_a;
    chan_a_gp_out_n_o == !$past(chan_a_stat_i.irq_out_en);
  endproperty
  a_gp_a: assert property (p_gp_a) else $error("gp out wrong");
  property p_oe_a;
    chan_a_irq_out_oe_o == $past(chan_a_stat_i.irq_out_en);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("irq enable wrong");
  property p_tx_a;
    chan_a_tx_ready_n_o == !$past(chan_a_stat_i.tx_ready);
  endproperty
  a_tx_a: assert property (p_tx_a) else $error("tx ready wrong");
  property p_rx_b;
    chan_b_rx_ready_n_o == !$past(chan_b_stat_i.rx_ready);
  endproperty
  a_rx_b: assert property (p_rx_b) else $error("rx ready wrong");
  property p_idle_rq;
    s_idle |-> !req_o.rd && !req_o.wr;
  endproperty
  a_idle_rq: assert property (p_idle_rq) else $error("access unselected");
  property p_idle_oe;
    s_idle |-> !data_oe_o;
  endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("bus driven");
  property p_rd;
    s_rd_fall |-> ##[2:4] req_o.rd;
  endproperty
  a_rd: assert property (p_rd) else $error("read not started");
  property p_rd_ans;
    req_o.rd |=> data_oe_o && !req_o.rd;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not driven");
endmodule // host_port_checker
bind host_bus_port host_port_checker u_chk (.*);
`default_nettype wire

//--- verif/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock and port bus side
  input wire logic ref_clk_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  // host pins
  output logic [2:0] sel_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic sa_n_o,
  output logic sb_n_o,
  output logic [7:0] bus_o
);
  logic drv;
  logic [7:0] hd, last;
  initial {sel_o, rd_n_o, wr_n_o, sa_n_o, sb_n_o, drv, hd, last} = {3'h0, 4'hF, 17'h0};
  // released bus shows inverse of last level
  assign bus_o = data_oe_o ? data_o : (drv ? hd : ~last);
  always @(posedge ref_clk_i) if (data_oe_o || drv) last <= bus_o;
  // ch: 0 a, 1 b, 2 none, 3 both
  task automatic access(input logic wr, input logic [1:0] ch, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(negedge ref_clk_i);
    {sel_o, hd, drv} = {a, d, wr};
    {sa_n_o, sb_n_o} = {ch[0] ^ ch[1], ~ch[0]};
    repeat (3) @(negedge ref_clk_i);
    if (wr) wr_n_o = 1'b0;
    else rd_n_o = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    {q, oe} = {bus_o, data_oe_o};
    {rd_n_o, wr_n_o} = 2'h3;
    repeat (4) @(negedge ref_clk_i);
    {sa_n_o, sb_n_o, drv} = 3'h6;
    repeat (4) @(negedge ref_clk_i);
  endtask
endmodule // host_model
`default_nettype wire

//--- verif/test_dual_uart_host_bus_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_dual_uart_host_bus_port;
  logic ref_clk_i, reset_n_i, read_strobe_n_i, write_strobe_n_i, data_oe_o;
  logic chan_a_select_n_i, chan_b_select_n_i, chan_a_irq_out_o, chan_a_irq_out_oe_o;
  logic chan_b_irq_out_o, chan_b_irq_out_oe_o, chan_a_gp_out_n_o, chan_b_gp_out_n_o;
  logic chan_a_tx_ready_n_o, chan_b_tx_ready_n_o, chan_a_rx_ready_n_o, chan_b_rx_ready_n_o;
  logic [2:0] reg_sel_i, a;
  logic [7:0] data_i, data_o, chan_a_rd_data_i, chan_b_rd_data_i, d, q, lw;
  logic [1:0] ch;
  logic wr, oe;
  host_port_pkg::reg_req_s req_o;
  host_port_pkg::reg_req_s exp_q[$];
  host_port_pkg::chan_stat_s chan_a_stat_i, chan_b_stat_i;
  int n_errors, compares, cycles;
  host_bus_port u_dut (.*);
  host_model u_host (.ref_clk_i(ref_clk_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .sel_o(reg_sel_i), .rd_n_o(read_strobe_n_i), .wr_n_o(write_strobe_n_i),
    .sa_n_o(chan_a_select_n_i), .sb_n_o(chan_b_select_n_i), .bus_o(data_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // result watcher and hang limit
  always @(negedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (req_o.rd || req_o.wr)
      check(16'(req_o), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hFFFF);
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  initial
  begin
    {reset_n_i, chan_a_rd_data_i, chan_b_rd_data_i, chan_a_stat_i, chan_b_stat_i} = '0;
    {n_errors, compares, cycles, lw} = '0;
    d = 8'($urandom(53148));
    repeat (12) @(negedge ref_clk_i);
    check(16'({chan_a_gp_out_n_o, chan_b_gp_out_n_o, chan_a_irq_out_oe_o, chan_b_irq_out_oe_o,
      data_oe_o}), 16'h0018);
    reset_n_i = 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      {wr, a, d, chan_a_rd_data_i, chan_b_rd_data_i} = 28'($urandom);
      ch = {1'(i >= 16), 1'($urandom)};
      if (!ch[1]) exp_q.push_back({!wr, wr, ch[0], a, wr ? d : lw});
      if (wr && !ch[1]) lw = d;
      u_host.access(wr, ch, a, d, q, oe);
      if (!wr && !ch[1]) check(16'(q), 16'(ch[0] ? chan_b_rd_data_i : chan_a_rd_data_i));
      check(16'(oe), 16'(!wr && !ch[1]));
      $display("access test %0d done", i);
    end
    check(16'(exp_q.size()), 16'h0000);
    for (int s = 0; s < 4; s++)
    begin
      chan_a_stat_i = 4'(s * 5);
      chan_b_stat_i = ~chan_a_stat_i;
      repeat (2) @(negedge ref_clk_i);
      check(16'({chan_a_irq_out_oe_o, chan_a_gp_out_n_o, chan_b_irq_out_oe_o, chan_b_gp_out_n_o}),
        16'({chan_a_stat_i[2], !chan_a_stat_i[2], chan_b_stat_i[2], !chan_b_stat_i[2]}));
      check(16'({chan_a_tx_ready_n_o, chan_a_rx_ready_n_o, chan_b_tx_ready_n_o, chan_b_rx_ready_n_o}),
        16'({!chan_a_stat_i[1], !chan_a_stat_i[0], !chan_b_stat_i[1], !chan_b_stat_i[0]}));
      check(16'({chan_a_irq_out_o, chan_b_irq_out_o}), 16'({chan_a_stat_i[3], chan_b_stat_i[3]}));
      $display("status test %0d done", s);
    end
    stop_test();
  end
endmodule // test_dual_uart_host_bus_port
`default_nettype wire
